// ===== gdfs_regs.sv
/*
  Fault flag register and input readback of a three-phase gate driver, with gate gating.
  Assumes fault detector inputs are synchronous to mclk; short and counter inputs are
  one-cycle events, pump undervoltage and temperatures are levels.
*/
`timescale 1ns/10ps
`default_nettype none
module gdfs_regs
  import gdfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic phase_u_low_in,
  input wire logic phase_u_high_in,
  input wire logic phase_v_low_in,
  input wire logic phase_v_high_in,
  input wire logic phase_w_low_in,
  input wire logic phase_w_high_in,
  input wire logic drv_en,
  input wire logic pump_uv,
  input wire logic [2:0] short_count_trig,
  input wire logic [2:0] ground_short_det,
  input wire logic [2:0] supply_short_det,
  input wire logic temp_prewarn,
  input wire logic temp_level_1,
  input wire logic temp_level_2,
  input wire logic temp_shutdown,
  output logic [2:0] gate_low_out,
  output logic [2:0] gate_high_out,
  output logic status_out,
  output logic [14:0] global_fault_flags
);
  logic frame_done;
  logic frame_wr;
  logic [6:0] frame_addr;
  logic [31:0] frame_data;
  logic [31:0] rd_word;
  logic [31:0] input_pin_readback;
  logic [14:0] next_flags;
  logic [14:0] set_vec;
  logic [14:0] clr_vec;
  logic drv_en_q;
  logic en_cycle;
  logic global_fault_flags_wr;
  logic [2:0] low_in;
  logic [2:0] high_in;
  logic [2:0] low_hold;
  logic [2:0] high_hold;
  logic drive_ok;

  function automatic int gdfs_pbit(input int phase, input int offs);
    return GDFS_BIT_U_COUNT + phase * GDFS_PHASE_STRIDE + offs;
  endfunction

  gdfs_spi u_gdfs_spi (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .rd_word(rd_word),
    .status_byte({7'h0, status_out}),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .frame_done(frame_done),
    .frame_wr(frame_wr),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );

  assign low_in = {phase_w_low_in, phase_v_low_in, phase_u_low_in};
  assign high_in = {phase_w_high_in, phase_v_high_in, phase_u_high_in};
  // live pins, bit 7 and upper bits read zero
  assign input_pin_readback = {21'h0, temp_level_2, temp_level_1, temp_prewarn, 1'b0, drv_en,
    phase_w_high_in, phase_w_low_in, phase_v_high_in, phase_v_low_in,
    phase_u_high_in, phase_u_low_in};

  always_comb begin
    if (frame_addr == GDFS_ADDR_GLOBAL_FAULT_FLAGS) begin
      rd_word = {17'h0, global_fault_flags};
    end else if (frame_addr == GDFS_ADDR_INPUT_PIN_READBACK) begin
      rd_word = input_pin_readback;
    end else begin
      rd_word = 32'h0;
    end
  end

  assign global_fault_flags_wr = frame_done && frame_wr && frame_addr == GDFS_ADDR_GLOBAL_FAULT_FLAGS;
  assign en_cycle = drv_en && !drv_en_q;

  always_comb begin
    set_vec = 15'h0;
    set_vec[GDFS_BIT_PREWARN] = temp_prewarn;
    set_vec[GDFS_BIT_OVERTEMP] = temp_shutdown;
    set_vec[GDFS_BIT_PUMP_UV] = pump_uv;
    for (int p = 0; p < 3; p++) begin
      set_vec[gdfs_pbit(p, 0)] = short_count_trig[p];
      set_vec[gdfs_pbit(p, 1)] = ground_short_det[p];
      set_vec[gdfs_pbit(p, 2)] = supply_short_det[p];
    end
    clr_vec = 15'h0;
    if (global_fault_flags_wr) begin
      clr_vec = frame_data[14:0];
      // reset indication may only be cleared while the drivers are enabled
      clr_vec[GDFS_BIT_RESET] = frame_data[GDFS_BIT_RESET] & drv_en;
      // overtemperature stays latched while the condition persists
      clr_vec[GDFS_BIT_OVERTEMP] = frame_data[GDFS_BIT_OVERTEMP] & ~temp_shutdown;
    end
    if (en_cycle) begin
      clr_vec = clr_vec | (~GDFS_FLAG_KEEP_ON_EN & ~({15{temp_shutdown}} & (15'h1 << GDFS_BIT_OVERTEMP)));
    end
    // set beats clear so an event in the clearing cycle is kept
    next_flags = ((global_fault_flags & ~clr_vec) | set_vec) & GDFS_FLAG_IMPL_MASK;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_fault_flags <= GDFS_FLAG_RESET_VAL;
      drv_en_q <= 1'b1;
    end else if (ce) begin
      global_fault_flags <= next_flags;
      drv_en_q <= drv_en;
    end
  end

  // a transistor latched off stays off until its flag is gone and its input is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_hold <= 3'h0;
      high_hold <= 3'h0;
    end else if (ce) begin
      for (int p = 0; p < 3; p++) begin
        if (ground_short_det[p]) begin
          high_hold[p] <= 1'b1;
        end else if (!global_fault_flags[gdfs_pbit(p, 1)] && !high_in[p]) begin
          high_hold[p] <= 1'b0;
        end
        if (supply_short_det[p]) begin
          low_hold[p] <= 1'b1;
        end else if (!global_fault_flags[gdfs_pbit(p, 2)] && !low_in[p]) begin
          low_hold[p] <= 1'b0;
        end
      end
    end
  end

  assign drive_ok = drv_en && !pump_uv && !global_fault_flags[GDFS_BIT_OVERTEMP];
  assign gate_low_out = low_in & ~low_hold & {3{drive_ok}};
  assign gate_high_out = high_in & ~high_hold & {3{drive_ok}};
  assign status_out = |(global_fault_flags & GDFS_FLAG_STATUS_MASK);

  property p_uv_off;
    @(posedge mclk) disable iff (!rst_n) pump_uv |-> gate_low_out == 3'h0 && gate_high_out == 3'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("drivers on during pump undervoltage");

  property p_uv_latch;
    @(posedge mclk) disable iff (!rst_n) ce && pump_uv |=> global_fault_flags[3] && status_out;
  endproperty
  a_uv_latch: assert property (p_uv_latch) else $error("undervoltage flag not latched");

  property p_count_u;
    @(posedge mclk) disable iff (!rst_n) ce && short_count_trig[0] |=> global_fault_flags[4];
  endproperty
  a_count_u: assert property (p_count_u) else $error("phase U counter flag missing");

  property p_count_w;
    @(posedge mclk) disable iff (!rst_n) ce && short_count_trig[2] |=> global_fault_flags[12];
  endproperty
  a_count_w: assert property (p_count_w) else $error("phase W counter flag missing");

  property p_gnd_v;
    @(posedge mclk) disable iff (!rst_n)
      ce && ground_short_det[1] |=> global_fault_flags[9] && gate_high_out[1] == 1'b0;
  endproperty
  a_gnd_v: assert property (p_gnd_v) else $error("phase V ground short not handled");

  property p_sup_u;
    @(posedge mclk) disable iff (!rst_n)
      ce && supply_short_det[0] |=> global_fault_flags[6] && gate_low_out[0] == 1'b0;
  endproperty
  a_sup_u: assert property (p_sup_u) else $error("phase U supply short not handled");

  property p_hold_w;
    @(posedge mclk) disable iff (!rst_n) global_fault_flags[13] |-> gate_high_out[2] == 1'b0;
  endproperty
  a_hold_w: assert property (p_hold_w) else $error("phase W high side on with ground flag");

  property p_status_or;
    @(posedge mclk) disable iff (!rst_n) status_out == |(global_fault_flags & 15'h777c);
  endproperty
  a_status_or: assert property (p_status_or) else $error("status pin not OR of flags");

  property p_holes;
    @(posedge mclk) disable iff (!rst_n) global_fault_flags[7] == 1'b0 && global_fault_flags[11] == 1'b0;
  endproperty
  a_holes: assert property (p_holes) else $error("reserved flag bit set");

  property p_w1c;
    @(posedge mclk) disable iff (!rst_n)
      ce && global_fault_flags_wr && frame_data[10] && !supply_short_det[1] |=> !global_fault_flags[10];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_en_keep;
    @(posedge mclk) disable iff (!rst_n)
      ce && en_cycle && global_fault_flags[0] |=> global_fault_flags[0];
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable cycle cleared reset flag");

  property p_readback;
    @(posedge mclk) disable iff (!rst_n)
      frame_addr == 7'h04 |-> rd_word[6:0] == {drv_en, high_in[2], low_in[2], high_in[1], low_in[1],
        high_in[0], low_in[0]} && rd_word[7] == 1'b0 && rd_word[10:8] == {temp_level_2, temp_level_1, temp_prewarn};
  endproperty
  a_readback: assert property (p_readback) else $error("input readback mismatch");

  property p_release;
    @(posedge mclk) disable iff (!rst_n)
      ce && high_hold[0] && high_in[0] && !ground_short_det[0] |=> high_hold[0];
  endproperty
  a_release: assert property (p_release) else $error("hold released with input high");

  c_global_fault_flags_write: cover property (@(posedge mclk) disable iff (!rst_n) global_fault_flags_wr);
  c_en_cycle: cover property (@(posedge mclk) disable iff (!rst_n) en_cycle && global_fault_flags[5]);
  c_read_input: cover property (@(posedge mclk) disable iff (!rst_n) frame_done && !frame_wr && frame_addr == 7'h04);
endmodule
`default_nettype wire

// ===== gdfs_pkg.sv
/*
  Constants for the gate driver fault status registers: register indices, flag bit
  positions, serial frame layout and reset values. Assumes a 250 MHz mclk domain.
*/
// Contract
// - pump undervoltage disables drivers, latches, shows status
// - phase U short counter sets bit 4
// - phase U ground short sets bit 5, holds off
// - phase U supply short sets bit 6, holds off
// - phase V short counter sets bit 8
// - phase V ground short sets bit 9, holds off
// - phase V supply short sets bit 10, holds off
// - phase W short counter sets bit 12
// - phase W ground short sets bit 13, holds off
// - phase W supply short sets bit 14, holds off
// - status pin is OR of fault flags except reset indication and prewarning
// - input readback at 0x04 shows gate inputs, enable
// - write one clears; enable cycle clears most flags
// - global bit 3 is pump undervoltage
package gdfs_pkg;
  localparam logic [6:0] GDFS_ADDR_GLOBAL_FAULT_FLAGS = 7'h01;
  localparam logic [6:0] GDFS_ADDR_INPUT_PIN_READBACK = 7'h04;
  localparam int GDFS_FLAG_W = 15;
  localparam int GDFS_BIT_RESET = 0;
  localparam int GDFS_BIT_PREWARN = 1;
  localparam int GDFS_BIT_OVERTEMP = 2;
  localparam int GDFS_BIT_PUMP_UV = 3;
  localparam int GDFS_BIT_U_COUNT = 4;
  localparam int GDFS_BIT_U_GROUND = 5;
  localparam int GDFS_BIT_U_SUPPLY = 6;
  localparam int GDFS_PHASE_STRIDE = 4;
  // bits 7 and 11 are holes in the map
  localparam logic [14:0] GDFS_FLAG_IMPL_MASK = 15'h777f;
  // flags kept through a drive enable cycle: reset indication and prewarning
  localparam logic [14:0] GDFS_FLAG_KEEP_ON_EN = 15'h0003;
  localparam logic [14:0] GDFS_FLAG_STATUS_MASK = 15'h777c;
  localparam logic [14:0] GDFS_FLAG_RESET_VAL = 15'h0001;
  localparam int GDFS_FRAME_BITS = 40;
  localparam int GDFS_FRAME_WR_BIT = 39;
  localparam int GDFS_FRAME_ADDR_LSB = 32;
  localparam int GDFS_IN_DRV_EN = 6;
  localparam int GDFS_IN_TEMP_LSB = 8;
endpackage

// ===== gdfs_spi.sv
/*
  Serial register port: 40-bit frames (write flag, 7-bit address, 32-bit data), msb first.
  Assumes cs_n, sclk and sdi are already synchronous to mclk and sclk is far slower than mclk.
  Read data of a frame is returned in the following frame, behind a status byte.
*/
`timescale 1ns/10ps
`default_nettype none
module gdfs_spi
  import gdfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [31:0] rd_word,
  input wire logic [7:0] status_byte,
  output logic sdo,
  output logic sdo_oe,
  output logic frame_done,
  output logic frame_wr,
  output logic [6:0] frame_addr,
  output logic [31:0] frame_data
);
  logic sclk_q;
  logic cs_q;
  logic [39:0] shift_in;
  logic [39:0] shift_out;
  logic [5:0] bit_cnt;
  logic [31:0] held_word;
  logic sclk_rise;
  logic sclk_fall;

  assign sclk_rise = sclk & ~sclk_q & ~cs_n;
  assign sclk_fall = ~sclk & sclk_q & ~cs_n;
  assign sdo = shift_out[39];
  assign sdo_oe = ~cs_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
    end else if (ce) begin
      sclk_q <= sclk;
      cs_q <= cs_n;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 40'h0;
      shift_out <= 40'h0;
      bit_cnt <= 6'h0;
    end else if (ce) begin
      if (cs_q && !cs_n) begin
        shift_out <= {status_byte, held_word};
        bit_cnt <= 6'h0;
      end else begin
        if (sclk_rise) begin
          shift_in <= {shift_in[38:0], sdi};
          // saturate: an overlong frame is dropped, not wrapped
          if (bit_cnt <= 6'(GDFS_FRAME_BITS)) begin
            bit_cnt <= bit_cnt + 6'h1;
          end
        end
        if (sclk_fall) begin
          shift_out <= {shift_out[38:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_done <= 1'b0;
      frame_wr <= 1'b0;
      frame_addr <= 7'h0;
      frame_data <= 32'h0;
    end else if (ce) begin
      frame_done <= !cs_q && cs_n && bit_cnt == 6'(GDFS_FRAME_BITS);
      if (!cs_q && cs_n) begin
        frame_wr <= shift_in[GDFS_FRAME_WR_BIT];
        frame_addr <= shift_in[38:32];
        frame_data <= shift_in[31:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      held_word <= 32'h0;
    end else if (ce && frame_done) begin
      held_word <= rd_word;
    end
  end
endmodule
`default_nettype wire

// ===== gdfs_host.sv
/*
  Host model for the gate driver fault status registers: a serial master that sends
  40-bit frames msb first and collects what the device shifts back.
  Assumes mclk is the device clock; all pins change just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module gdfs_host (
  input wire logic mclk,
  input wire logic sdo,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // half period of two mclk keeps sclk well inside the device's sampling limit
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    @(posedge mclk) cs_n <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 39; i >= 0; i--) begin
      // the device moves sdo on every sclk fall, the first one too, so the bit is taken before the fall
      rx[i] = sdo;
      sclk <= 1'b0;
      sdi <= tx[i];
      repeat (2) @(posedge mclk);
      sclk <= 1'b1;
      repeat (2) @(posedge mclk);
    end
    cs_n <= 1'b1;
    // released line shows no stale bit
    sdi <= ~sdi;
    // gap covers frame completion and the write landing in the flags
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== gate_driver_fault_status_regs_test.sv
/*
  Self-checking bench for the gate driver fault status registers.
  Assumes gdfs_pkg, gdfs_regs and the host model gdfs_host are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module gate_driver_fault_status_regs_test
  import gdfs_pkg::*;
;
  localparam int LIMIT = 20000;
  logic mclk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, drv_en, pump_uv, status_out, prewarn, lvl1, lvl2;
  logic [2:0] g_lo, g_hi, cnt_trig, gnd_det, sup_det, gate_low_out, gate_high_out;
  logic [14:0] flags, exp;
  logic [31:0] d;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  gdfs_host u_gdfs_host (.mclk(mclk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  gdfs_regs u_gdfs_regs (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .phase_u_low_in(g_lo[0]), .phase_u_high_in(g_hi[0]), .phase_v_low_in(g_lo[1]),
    .phase_v_high_in(g_hi[1]), .phase_w_low_in(g_lo[2]), .phase_w_high_in(g_hi[2]),
    .drv_en(drv_en), .pump_uv(pump_uv), .short_count_trig(cnt_trig), .ground_short_det(gnd_det),
    .supply_short_det(sup_det), .temp_prewarn(prewarn), .temp_level_1(lvl1), .temp_level_2(lvl2),
    .temp_shutdown(1'b0), .gate_low_out(gate_low_out), .gate_high_out(gate_high_out),
    .status_out(status_out), .global_fault_flags(flags)
  );

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp_v, input string msg);
    checks_done++;
    if (seen !== exp_v) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp_v);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    logic [39:0] r;
    u_gdfs_host.xfer({1'b1, a, v}, r);
  endtask

  // read data comes back one frame late, so the address is sent twice
  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    logic [39:0] r;
    u_gdfs_host.xfer({1'b0, a, 32'h0}, r);
    u_gdfs_host.xfer({1'b0, a, 32'h0}, r);
    v = r[31:0];
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    rst_n = 1'b0;
    drv_en = 1'b1;
    pump_uv = 1'b0;
    prewarn = 1'b0;
    lvl1 = 1'b0;
    lvl2 = 1'b0;
    g_lo = 3'h0;
    g_hi = 3'h0;
    cnt_trig = 3'h0;
    gnd_det = 3'h0;
    sup_det = 3'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(flags, GDFS_FLAG_RESET_VAL, "reset flags");
    chk(status_out, 1'b0, "reset status");
    chk(sdo_oe, 1'b0, "port idle");
    @(posedge mclk);
    g_lo <= 3'h5;
    g_hi <= 3'h2;
    prewarn <= 1'b1;
    lvl2 <= 1'b1;
    rd(GDFS_ADDR_INPUT_PIN_READBACK, d);
    chk(d, 32'h0000_0559, "readback a");
    g_lo <= 3'h2;
    g_hi <= 3'h5;
    prewarn <= 1'b0;
    lvl1 <= 1'b1;
    lvl2 <= 1'b0;
    rd(GDFS_ADDR_INPUT_PIN_READBACK, d);
    chk(d, 32'h0000_0266, "readback b");
    g_lo <= 3'h0;
    g_hi <= 3'h0;
    wr(GDFS_ADDR_GLOBAL_FAULT_FLAGS, 32'h0000_7fff);
    rd(GDFS_ADDR_GLOBAL_FAULT_FLAGS, d);
    chk(d, 32'h0, "clear all");
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge mclk);
        g_lo[p] <= 1'b1;
        g_hi[p] <= 1'b1;
        cnt_trig[p] <= (k == 0);
        gnd_det[p] <= (k == 1);
        sup_det[p] <= (k == 2);
        @(posedge mclk);
        cnt_trig <= 3'h0;
        gnd_det <= 3'h0;
        sup_det <= 3'h0;
        #1;
        exp = 15'h0;
        exp[GDFS_BIT_U_COUNT + GDFS_PHASE_STRIDE * p + k] = 1'b1;
        chk(flags, exp, "fault flag");
        chk(status_out, 1'b1, "status on");
        chk({gate_low_out[p], gate_high_out[p]}, {k != 2, k != 1}, "gate hold");
        wr(GDFS_ADDR_GLOBAL_FAULT_FLAGS, {17'h0, exp});
        chk(flags, 32'h0, "flag cleared");
        chk(status_out, 1'b0, "status off");
        chk({gate_low_out[p], gate_high_out[p]}, {k != 2, k != 1}, "held after clear");
        @(posedge mclk);
        // the controller switches the transistor off to release the hold
        g_lo[p] <= 1'b0;
        g_hi[p] <= 1'b0;
        repeat (2) @(posedge mclk);
        g_lo[p] <= 1'b1;
        g_hi[p] <= 1'b1;
        @(posedge mclk);
        #1;
        chk({gate_low_out[p], gate_high_out[p]}, 2'h3, "released");
        @(posedge mclk);
        g_lo[p] <= 1'b0;
        g_hi[p] <= 1'b0;
      end
    end
    // second reset in mid-run brings the reset indication back for the enable cycle test
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(flags, GDFS_FLAG_RESET_VAL, "second reset");
    chk(status_out, 1'b0, "second reset status");
    @(posedge mclk);
    g_lo <= 3'h7;
    g_hi <= 3'h7;
    pump_uv <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({gate_low_out, gate_high_out}, 6'h0, "pump off");
    chk(flags[GDFS_BIT_PUMP_UV], 1'b1, "pump flag");
    chk(status_out, 1'b1, "pump status");
    @(posedge mclk);
    pump_uv <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(flags, 15'h0009, "pump latched");
    chk({gate_low_out, gate_high_out}, 6'h3f, "pump back");
    @(posedge mclk);
    cnt_trig <= 3'h7;
    gnd_det <= 3'h7;
    sup_det <= 3'h7;
    prewarn <= 1'b1;
    @(posedge mclk);
    cnt_trig <= 3'h0;
    gnd_det <= 3'h0;
    sup_det <= 3'h0;
    prewarn <= 1'b0;
    g_lo <= 3'h0;
    g_hi <= 3'h0;
    rd(GDFS_ADDR_GLOBAL_FAULT_FLAGS, d);
    chk(d, 32'h0000_777b, "all faults");
    @(posedge mclk);
    drv_en <= 1'b0;
    @(posedge mclk);
    drv_en <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(flags, 15'h0003, "enable cycle");
    chk(status_out, 1'b0, "enable status");
    report_and_stop();
  end
endmodule
`default_nettype wire
